/* File: rtl/hsipc_defines.svh */
// Constants for the high-speed interrupt and pulse-catch unit
`ifndef HSIPC_DEFINES_SVH
`define HSIPC_DEFINES_SVH

// ************************************************************
// Timing
// ************************************************************
`define HSIPC_CLK_PERIOD_NS 10
`define HSIPC_TICK_MS_NS    1000000
`define HSIPC_MS_CYC        (`HSIPC_TICK_MS_NS / `HSIPC_CLK_PERIOD_NS)
`define HSIPC_GAP_NS        500000
`define HSIPC_GAP_CYC       (`HSIPC_GAP_NS / `HSIPC_CLK_PERIOD_NS)

// ************************************************************
// Register indices and reset value
// ************************************************************
`define HSIPC_IDX_MODE      3'h0
`define HSIPC_IDX_CFG_A     3'h1
`define HSIPC_IDX_CFG_B     3'h2
`define HSIPC_IDX_CFG_C     3'h3
`define HSIPC_IDX_CFG_D     3'h4
`define HSIPC_REG_RESET     16'h0000

// ************************************************************
// Codes
// ************************************************************
`define HSIPC_MODE_IRQ      8'h40
`define HSIPC_MODE_CATCH    8'h50
`define HSIPC_CODE_EXT      16'h0004
`define HSIPC_CODE_CATCH    16'h0005
`define HSIPC_TIMED_DIGIT   4'h4
`define HSIPC_FILT_CODE     8'h06
`define HSIPC_FILT_MIN      7'h0A
`define HSIPC_TMR_MIN       10'h005

// ************************************************************
// Processor-side APB map
// ************************************************************
`define HSIPC_OFF_CTRL      8'h00
`define HSIPC_OFF_STATUS    8'h04
`define HSIPC_OFF_IRQ_CNT   8'h08
`define HSIPC_OFF_CFG_LO    8'h10
`define HSIPC_OFF_CFG_HI    8'h20
`define HSIPC_CFG_BASE_IDX  4'h4
`define HSIPC_CTRL_IRQ_EN   0
`define HSIPC_CTRL_SCAN_END 1
`define HSIPC_ST_CATCH      4
`define HSIPC_ST_IRQ        5

`endif

/* File: rtl/hsipc_pkg.sv */
// Types shared by both ends of the unit
package hsipc_pkg;
    typedef logic [15:0] hsipc_word_t;
    typedef enum logic [2:0] {
        HSIPC_M_IDLE  = 3'b001,
        HSIPC_M_IRQ   = 3'b010,
        HSIPC_M_CATCH = 3'b100
    } hsipc_mode_t;
    typedef enum logic [2:0] {
        HSIPC_C_EMPTY = 3'b001,
        HSIPC_C_HELD  = 3'b010,
        HSIPC_C_SHOWN = 3'b100
    } hsipc_catch_t;
endpackage : hsipc_pkg

/* File: rtl/hsipc_if.sv */
// Link between the unit and the processor
`timescale 1ns/1ps
interface hsipc_if;
    import hsipc_pkg::*;
    logic        cfg_wr;
    logic [2:0]  cfg_idx;
    hsipc_word_t cfg_wdata;
    hsipc_word_t cfg_rdata;
    logic        irq_req;
    logic        irq_ack;
    logic        scan_end;
    logic        catch_flag_contact;
    logic [3:0]  logic_in;

    modport device (
        input  cfg_wr, cfg_idx, cfg_wdata, irq_ack, scan_end,
        output cfg_rdata, irq_req, catch_flag_contact, logic_in
    );
    modport cpu (
        output cfg_wr, cfg_idx, cfg_wdata, irq_ack, scan_end,
        input  cfg_rdata, irq_req, catch_flag_contact, logic_in
    );
endinterface : hsipc_if

/* File: rtl/hsipc_filter.sv */
// Delay filter for one discrete input
`timescale 1ns/1ps
module hsipc_filter (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ms_tick,
    input  wire logic       raw,
    input  wire logic [6:0] ftime,
    output logic            filt
);
    import hsipc_pkg::*;
    logic [6:0] cnt;
    wire  [6:0] next_cnt = cnt + 7'h01;
    wire        expired  = ms_tick && (next_cnt >= ftime);

    // Both edges move only after the input has differed for the whole time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 7'h00;
            filt <= 1'b0;
        end else if (raw == filt) begin
            cnt <= 7'h00;
        end else if (expired) begin
            cnt  <= 7'h00;
            filt <= raw;
        end else if (ms_tick) begin
            cnt <= next_cnt;
        end
    end
endmodule : hsipc_filter

/* File: rtl/hsipc_device.sv */
// High-speed input unit: interrupt and pulse-catch modes
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "hsipc_defines.svh"
module hsipc_device #(
    parameter int MS_CYC  = `HSIPC_MS_CYC,
    parameter int GAP_CYC = `HSIPC_GAP_CYC
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    hsipc_if.device         link,
    input  wire logic [3:0] field_in
);
    import hsipc_pkg::*;

    localparam int MSW  = $clog2(MS_CYC + 1);
    localparam int GAPW = $clog2(GAP_CYC + 1);

    // ************************************************************
    // BCD helpers
    // ************************************************************
    function automatic logic bcd_ok(input logic [3:0] d);
        bcd_ok = (d <= 4'h9);
    endfunction : bcd_ok

    function automatic logic [9:0] bcd3(input logic [11:0] b);
        bcd3 = 10'(b[11:8] * 7'd100) + 10'(b[7:4] * 4'd10) + 10'(b[3:0]);
    endfunction : bcd3

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [3:0] sync1;
    logic [3:0] sync2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= field_in;
            sync2 <= sync1;
        end
    end

    // ************************************************************
    // Configuration words
    // ************************************************************
    hsipc_word_t cfg_reg [0:4];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++) begin
                cfg_reg[i] <= `HSIPC_REG_RESET;
            end
        end else if (link.cfg_wr && (link.cfg_idx <= `HSIPC_IDX_CFG_D)) begin
            cfg_reg[link.cfg_idx] <= link.cfg_wdata;
        end
    end

    assign link.cfg_rdata = (link.cfg_idx <= `HSIPC_IDX_CFG_D) ?
                            cfg_reg[link.cfg_idx] : `HSIPC_REG_RESET;

    // ************************************************************
    // Mode and source decode
    // ************************************************************
    wire [7:0]   mode_code = cfg_reg[`HSIPC_IDX_MODE][7:0];
    hsipc_word_t cfg_a;
    assign cfg_a = cfg_reg[`HSIPC_IDX_CFG_A];

    // The high byte of the mode word is not looked at here
    hsipc_mode_t mode;
    assign mode = (mode_code == `HSIPC_MODE_IRQ)   ? HSIPC_M_IRQ :
                  (mode_code == `HSIPC_MODE_CATCH) ? HSIPC_M_CATCH :
                  HSIPC_M_IDLE;

    wire [9:0] tmr_period = bcd3(cfg_a[15:4]);
    wire       src_ext    = (mode == HSIPC_M_IRQ) && (cfg_a == `HSIPC_CODE_EXT);
    // A malformed timed word raises nothing rather than a wrong period
    wire       src_tmr    = (mode == HSIPC_M_IRQ) && !src_ext &&
                            (cfg_a[3:0] == `HSIPC_TIMED_DIGIT) &&
                            bcd_ok(cfg_a[15:12]) && bcd_ok(cfg_a[11:8]) &&
                            bcd_ok(cfg_a[7:4]) &&
                            (tmr_period >= `HSIPC_TMR_MIN);
    wire       catch_on   = (mode == HSIPC_M_CATCH) &&
                            (cfg_a == `HSIPC_CODE_CATCH);

    // ************************************************************
    // Millisecond timebase
    // ************************************************************
    logic [MSW-1:0] ms_cnt;
    wire            ms_tick = (ms_cnt == MSW'(MS_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt <= '0;
        end else if (ms_tick) begin
            ms_cnt <= '0;
        end else begin
            ms_cnt <= ms_cnt + MSW'(1);
        end
    end

    // ************************************************************
    // Filtered inputs
    // ************************************************************
    logic [6:0] ftime [0:3];
    logic [3:0] filt;

    generate
        for (genvar g = 0; g < 4; g++) begin : g_filt
            hsipc_word_t w;
            wire [6:0]   t;
            wire         ok;
            assign w  = cfg_reg[g + 1];
            assign t  = 7'(w[15:12] * 4'd10) + 7'(w[11:8]);
            // Out-of-range or malformed time falls back to the shortest one
            assign ok = (w[7:0] == `HSIPC_FILT_CODE) && bcd_ok(w[15:12]) &&
                        bcd_ok(w[11:8]) && (t >= `HSIPC_FILT_MIN);
            assign ftime[g] = ok ? t : `HSIPC_FILT_MIN;

            hsipc_filter u_filt (
                .pclk    (pclk),
                .presetn (presetn),
                .ms_tick (ms_tick),
                .raw     (sync2[g]),
                .ftime   ((g == 0 && src_tmr) ? ftime[1] : ftime[g]),
                .filt    (filt[g])
            );
        end
    endgenerate

    // Raw input a is hidden from the program while catching
    assign link.logic_in[0]   = src_ext  ? sync2[0] :
                                catch_on ? 1'b0 : filt[0];
    assign link.logic_in[3:1] = filt[3:1];

    // ************************************************************
    // Input a edge with merge window
    // ************************************************************
    logic            a_prev;
    logic [GAPW-1:0] gap_cnt;
    wire             a_rise = sync2[0] && !a_prev;
    // Edges closer than the least period belong to the current pulse
    wire             a_edge = a_rise && (gap_cnt == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_prev  <= 1'b0;
            gap_cnt <= '0;
        end else begin
            a_prev <= sync2[0];
            if (a_edge) begin
                gap_cnt <= GAPW'(GAP_CYC - 1);
            end else if (gap_cnt != '0) begin
                gap_cnt <= gap_cnt - GAPW'(1);
            end
        end
    end

    // ************************************************************
    // Interrupt sources and held request
    // ************************************************************
    logic [9:0] per_cnt;
    wire  [9:0] next_per_cnt = per_cnt + 10'h001;
    wire        tmr_evt = src_tmr && ms_tick && (next_per_cnt >= tmr_period);
    wire        ext_evt = src_ext && a_edge;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt <= 10'h000;
        end else if (!src_tmr || tmr_evt) begin
            per_cnt <= 10'h000;
        end else if (ms_tick) begin
            per_cnt <= next_per_cnt;
        end
    end

    // A new event in the acknowledge cycle keeps the request up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.irq_req <= 1'b0;
        end else if (tmr_evt || ext_evt) begin
            link.irq_req <= 1'b1;
        end else if (link.irq_ack) begin
            link.irq_req <= 1'b0;
        end
    end

    // ************************************************************
    // Pulse catch latch
    // ************************************************************
    hsipc_catch_t cst;
    hsipc_catch_t next_cst;
    wire          catch_evt = catch_on && a_edge;

    always_comb begin
        next_cst = cst;
        case (cst)
            HSIPC_C_EMPTY: begin
                if (catch_evt) next_cst = HSIPC_C_HELD;
            end
            HSIPC_C_HELD: begin
                if (link.scan_end) next_cst = HSIPC_C_SHOWN;
            end
            HSIPC_C_SHOWN: begin
                if (catch_evt) next_cst = HSIPC_C_HELD;
                else if (link.scan_end) next_cst = HSIPC_C_EMPTY;
            end
            default: next_cst = HSIPC_C_EMPTY;
        endcase
        if (!catch_on) next_cst = HSIPC_C_EMPTY;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cst                     <= HSIPC_C_EMPTY;
            link.catch_flag_contact <= 1'b0;
        end else begin
            cst                     <= next_cst;
            link.catch_flag_contact <= (next_cst == HSIPC_C_SHOWN);
        end
    end
endmodule : hsipc_device

/* File: rtl/hsipc_cpu.sv */
// Processor end: APB registers driving the unit's link
`timescale 1ns/1ps
`include "hsipc_defines.svh"
module hsipc_cpu (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    hsipc_if.cpu             link
);
    import hsipc_pkg::*;

    // ************************************************************
    // Address decode
    // ************************************************************
    wire hit_ctrl = (paddr == `HSIPC_OFF_CTRL);
    wire hit_st   = (paddr == `HSIPC_OFF_STATUS);
    wire hit_cnt  = (paddr == `HSIPC_OFF_IRQ_CNT);
    wire hit_cfg  = (paddr >= `HSIPC_OFF_CFG_LO) && (paddr <= `HSIPC_OFF_CFG_HI) &&
                    (paddr[1:0] == 2'h0);
    wire hit      = hit_ctrl || hit_st || hit_cnt || hit_cfg;
    wire setup_rd = psel && !penable && !pwrite;
    wire acc_wr   = psel && penable && pwrite && hit;

    logic        irq_en;
    logic [15:0] irq_cnt;

    assign pready         = 1'b1;
    assign pslverr        = psel && penable && !hit;
    assign link.cfg_idx   = 3'(paddr[5:2] - `HSIPC_CFG_BASE_IDX);
    assign link.cfg_wdata = pwdata[15:0];
    assign link.cfg_wr    = acc_wr && hit_cfg;
    assign link.scan_end  = acc_wr && hit_ctrl && pwdata[`HSIPC_CTRL_SCAN_END];
    // Taken at once; the routine only runs when enabled
    assign link.irq_ack   = link.irq_req;

    wire [31:0] st_word = {26'h0, link.irq_req, link.catch_flag_contact, link.logic_in};
    wire [31:0] rd_mux  = hit_ctrl ? {31'h0, irq_en} :
                          hit_st   ? st_word :
                          hit_cnt  ? {16'h0, irq_cnt} :
                          hit_cfg  ? {16'h0, link.cfg_rdata} : 32'h0;

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            irq_en  <= 1'b0;
            irq_cnt <= 16'h0;
        end else begin
            if (setup_rd) prdata <= rd_mux;
            if (acc_wr && hit_ctrl) irq_en <= pwdata[`HSIPC_CTRL_IRQ_EN];
            if (link.irq_req && irq_en) irq_cnt <= irq_cnt + 16'h1;
        end
    end
endmodule : hsipc_cpu

/* File: testbench/hsipc_asserts.sv */
// Concurrent checks on the link between the unit and the processor
`timescale 1ns/1ps
`include "hsipc_defines.svh"
module hsipc_asserts
    import hsipc_pkg::*;
#(
    parameter int MS_CYC  = 100,
    parameter int GAP_CYC = 50
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               cfg_wr,
    input wire logic [2:0]         cfg_idx,
    input wire hsipc_pkg::hsipc_word_t cfg_wdata,
    input wire hsipc_pkg::hsipc_word_t cfg_rdata,
    input wire logic               irq_req,
    input wire logic               irq_ack,
    input wire logic               scan_end,
    input wire logic               catch_flag_contact,
    input wire logic [3:0]         logic_in
);
    // ************************************************************
    // Shadow of the configuration words
    // ************************************************************
    hsipc_word_t shadow [0:4];
    logic        irq_mode_d;
    logic        ext_mode_d;
    logic        catch_mode_d;
    logic        seen;
    logic [31:0] gap_cnt;
    wire         irq_mode   = shadow[0][7:0] == `HSIPC_MODE_IRQ;
    wire         catch_mode = shadow[0][7:0] == `HSIPC_MODE_CATCH
                              && shadow[1] == `HSIPC_CODE_CATCH;
    wire         ext_mode   = irq_mode && shadow[1] == `HSIPC_CODE_EXT;
    wire [11:0]  bcd        = shadow[1][15:4];
    wire         bcd_ok     = bcd[11:8] < 4'hA && bcd[7:4] < 4'hA && bcd[3:0] < 4'hA;
    wire [31:0]  per_ms     = 32'(bcd[11:8]) * 100 + 32'(bcd[7:4]) * 10 + 32'(bcd[3:0]);
    // Invalid or too short periods give no interrupts, so they stay unchecked
    wire         tmr_mode   = irq_mode && shadow[1][3:0] == `HSIPC_TIMED_DIGIT
                              && bcd_ok && per_ms >= 5;
    wire [15:0]  exp_rdata  = (cfg_idx <= 3'h4) ? shadow[cfg_idx] : 16'h0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++) shadow[i] <= `HSIPC_REG_RESET;
            irq_mode_d   <= 1'b0;
            ext_mode_d   <= 1'b0;
            catch_mode_d <= 1'b0;
            seen         <= 1'b0;
            gap_cnt      <= 32'h0000_0000;
        end else begin
            if (cfg_wr && cfg_idx <= 3'h4) shadow[cfg_idx] <= cfg_wdata;
            irq_mode_d   <= irq_mode;
            ext_mode_d   <= ext_mode;
            catch_mode_d <= catch_mode;
            seen         <= cfg_wr ? 1'b0 : (irq_req ? 1'b1 : seen);
            gap_cnt      <= irq_req ? 32'h0000_0001 : gap_cnt + 32'h0000_0001;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence shown_scan;
        catch_flag_contact && scan_end;
    endsequence

    cfg_read_a: assert property (cfg_rdata == exp_rdata)
        else $error("config word readback differs");
    ack_follow_a: assert property (irq_req |-> irq_ack)
        else $error("request not acknowledged");
    irq_single_a: assert property (irq_req |=> !irq_req)
        else $error("request held after acknowledge");
    irq_mode_a: assert property (!irq_mode && !irq_mode_d |-> !irq_req)
        else $error("request outside interrupt mode");
    ext_irq_a: assert property (ext_mode && ext_mode_d && $rose(logic_in[0])
        && gap_cnt > GAP_CYC + 4 |-> ##[0:2] irq_req)
        else $error("external edge gave no request");
    tmr_period_a: assert property (tmr_mode && seen && irq_req
        |-> gap_cnt == per_ms * MS_CYC)
        else $error("timed period wrong");
    catch_rise_a: assert property ($rose(catch_flag_contact) |-> $past(scan_end))
        else $error("contact rose without scan end");
    catch_clear_a: assert property (shown_scan |=> !catch_flag_contact)
        else $error("contact kept past one scan");
    catch_hide_a: assert property (catch_mode && catch_mode_d |-> !logic_in[0])
        else $error("raw input a visible in catch mode");
endmodule : hsipc_asserts

/* File: testbench/tb_hs_interrupt_pulse_catch.sv */
// Bench driving the processor end over APB with the unit as its partner
`timescale 1ns/1ps
`include "hsipc_defines.svh"
module tb_hs_interrupt_pulse_catch;
    import hsipc_pkg::*;
    localparam int MS  = 100;
    localparam int GAP = 50;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, c0;
    logic [3:0]  field_in;
    int          error_cnt = 0;
    int          n_compared = 0;

    hsipc_if link();
    hsipc_cpu hsipc_cpu_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    hsipc_device #(.MS_CYC(MS), .GAP_CYC(GAP)) hsipc_device_i (.pclk(pclk),
        .presetn(presetn), .link(link), .field_in(field_in));
    hsipc_asserts #(.MS_CYC(MS), .GAP_CYC(GAP)) hsipc_asserts_i (.pclk(pclk),
        .presetn(presetn), .cfg_wr(link.cfg_wr), .cfg_idx(link.cfg_idx),
        .cfg_wdata(link.cfg_wdata), .cfg_rdata(link.cfg_rdata), .irq_req(link.irq_req),
        .irq_ack(link.irq_ack), .scan_end(link.scan_end),
        .catch_flag_contact(link.catch_flag_contact), .logic_in(link.logic_in));

    always #5 pclk = ~pclk;

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Starts one edge later so a release and a new setup never share a time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
                       input string what);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rd & mask, exp);
    endtask : rdc

    task automatic pulse(input int b, input int hi, input int lo);
        field_in[b] <= 1'b1;
        repeat (hi) @(posedge pclk);
        field_in[b] <= 1'b0;
        repeat (lo) @(posedge pclk);
    endtask : pulse

    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        logic [15:0] pat [5];
        pat = '{16'h2040, 16'h0054, 16'h1006, 16'h1006, 16'h2006};
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h0000_0000;
        field_in = 4'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rdc(8'h10 + 8'(4 * i), '1, 32'h0, "reset word");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'h10 + 8'(4 * i), {16'hABCD, pat[i]});
            rdc(8'h10 + 8'(4 * i), '1, {16'h0000, pat[i]}, "word");
        end
        apb(1'b1, 8'h40, 32'h1234_5678);
        check("unmapped err", {31'h0, err}, 32'h1);
        rdc(8'h40, '1, 32'h0, "unmapped read");
        // Timed mode: a follows b's 10 ms, d has 20 ms, c pulse too short
        field_in <= 4'b1111;
        repeat (500) @(posedge pclk);
        field_in[2] <= 1'b0;
        rdc(`HSIPC_OFF_STATUS, 32'hF, 32'h0, "filt early");
        repeat (700) @(posedge pclk);
        rdc(`HSIPC_OFF_STATUS, 32'hF, 32'h3, "filt ab on");
        repeat (1000) @(posedge pclk);
        rdc(`HSIPC_OFF_STATUS, 32'hF, 32'hB, "filt d on");
        field_in <= 4'b0000;
        repeat (500) @(posedge pclk);
        rdc(`HSIPC_OFF_STATUS, 32'hF, 32'hB, "filt hold");
        repeat (700) @(posedge pclk);
        rdc(`HSIPC_OFF_STATUS, 32'hF, 32'h8, "filt ab off");
        repeat (1000) @(posedge pclk);
        rdc(`HSIPC_OFF_STATUS, 32'hF, 32'h0, "filt d off");
        apb(1'b1, `HSIPC_OFF_CTRL, 32'h1);
        rdc(`HSIPC_OFF_CTRL, '1, 32'h1, "irq enable");
        // A missing timed request within 700 cycles counts as a mismatch
        for (int n = 0; n < 700 && link.irq_req !== 1'b1; n++) @(posedge pclk);
        check("timed request", {31'h0, link.irq_req}, 32'h1);
        apb(1'b0, `HSIPC_OFF_IRQ_CNT, 32'h0);
        c0 = rd;
        repeat (1750) @(posedge pclk);
        rdc(`HSIPC_OFF_IRQ_CNT, '1, c0 + 3, "timed count");
        apb(1'b1, 8'h14, 32'h0044);
        apb(1'b0, `HSIPC_OFF_IRQ_CNT, 32'h0);
        c0 = rd;
        repeat (1200) @(posedge pclk);
        rdc(`HSIPC_OFF_IRQ_CNT, '1, c0, "bad period");
        apb(1'b1, 8'h14, 32'h0004);
        repeat (3) pulse(0, 10, 70);
        rdc(`HSIPC_OFF_IRQ_CNT, '1, c0 + 3, "ext count");
        pulse(0, 10, 20);
        pulse(0, 10, 70);
        rdc(`HSIPC_OFF_IRQ_CNT, '1, c0 + 4, "ext merged");
        apb(1'b1, `HSIPC_OFF_CTRL, 32'h0);
        pulse(0, 10, 70);
        rdc(`HSIPC_OFF_IRQ_CNT, '1, c0 + 4, "ext disabled");
        // Catch mode: second edge inside the merge window leaves the contact shown
        apb(1'b1, 8'h10, 32'h2050);
        apb(1'b1, 8'h14, 32'h0005);
        pulse(0, 10, 0);
        rdc(`HSIPC_OFF_STATUS, 32'h1F, 32'h0, "catch held");
        apb(1'b1, `HSIPC_OFF_CTRL, 32'h2);
        field_in[0] <= 1'b1;
        rdc(`HSIPC_OFF_STATUS, 32'h1F, 32'h10, "catch shown");
        apb(1'b1, `HSIPC_OFF_CTRL, 32'h2);
        rdc(`HSIPC_OFF_STATUS, 32'h1F, 32'h0, "catch cleared");
        field_in[0] <= 1'b0;
        repeat (70) @(posedge pclk);
        pulse(0, 10, 0);
        apb(1'b1, `HSIPC_OFF_CTRL, 32'h2);
        rdc(`HSIPC_OFF_STATUS, 32'h1F, 32'h10, "catch again");
        close_out();
    end

    initial begin
        repeat (40000) @(posedge pclk);
        error_cnt++;
        close_out();
    end
endmodule : tb_hs_interrupt_pulse_catch
